// ===== hdl/pwei_cfg.svh
`ifndef PWEI_CFG_SVH
`define PWEI_CFG_SVH
// register indices; byte address is four times the index
`define PWEI_IDX_WAKE_FLAGS    12'h013
`define PWEI_IDX_WAKE_ENABLES  12'h017
`define PWEI_IDX_INT_FLAGS     12'h01b
`define PWEI_IDX_INT_MASK      12'h01f
`define PWEI_IDX_IRQ_STATUS    12'h040
`define PWEI_IDX_IRQ_MASK      12'h041
`define PWEI_ADDR_W            14
// bit positions
`define PWEI_BIT_ENERGY        0
`define PWEI_BIT_LINK_UP       1
`define PWEI_BIT_WAKE_FRAME    2
`define PWEI_BIT_FILTER        0
`define PWEI_BIT_PHY           1
`define PWEI_BIT_SERDES_AN     3
// writable field masks
`define PWEI_WAKE_MASK         8'h07
`define PWEI_INT_MASK_BITS     8'h0b
// reset values
`define PWEI_RST_WAKE_FLAGS    8'h00
`define PWEI_RST_WAKE_ENABLES  8'h00
`define PWEI_RST_INT_MASK      8'h00
`define PWEI_RST_IRQ_MASK      8'h00
// port numbering
`define PWEI_SERDES_PORT       3'd7
`define PWEI_MAC_ADDR_W        48
`endif

// ===== hdl/pwei_pkg.sv
package pwei_pkg;
    typedef struct packed {
        logic        valid;
        logic [47:0] dest_addr;
    } pwei_wake_frame_t;

    typedef struct packed {
        logic energy;
        logic link_up;
        logic wake_frame;
    } pwei_wake_evt_t;

    typedef struct packed {
        logic serdes_an;
        logic phy;
        logic filter;
    } pwei_int_src_t;

    typedef struct packed {
        logic        sel;
        logic        write;
        logic [13:0] addr;
    } pwei_bus_req_t;

    typedef enum logic [2:0] {
        PWEI_IDLE  = 3'b001,
        PWEI_WRITE = 3'b010,
        PWEI_READ  = 3'b100
    } pwei_bus_state_t;
endpackage

// ===== hdl/pwei_sync.sv
`timescale 1ns/100ps
module pwei_sync
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    initial
    begin
        if (WIDTH < 1) $error("pwei_sync: WIDTH must be at least 1");
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            meta_q   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// ===== hdl/pwei_edge.sv
`timescale 1ns/100ps
module pwei_edge
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic [WIDTH-1:0] level_in,
    output logic      [WIDTH-1:0] rise_out
);
    logic [WIDTH-1:0] last_q;

    initial
    begin
        if (WIDTH < 1) $error("pwei_edge: WIDTH must be at least 1");
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            last_q <= '0;
        else
            last_q <= level_in;
    end

    assign rise_out = level_in & ~last_q;
endmodule

// ===== hdl/pwei_top.sv
//Contract
//- wake-frame flag bit 2 sets only when frame destination equals switch MAC address.
//- link-up flag bit 1 sets on link up, integrated-PHY ports only.
//- energy flag bit 0 sets on cable energy, integrated-PHY ports only.
//- wake-frame enable bit 2 gates wake-frame detection onto the power event pin.
//- link-up enable bit 1 gates link-up detection onto the power event pin.
//- energy enable bit 0 gates energy detection onto the power event pin.
//- status bit 3 reports serial-link autonegotiation done, port 7 only.
//- status bit 1 shows any pending PHY interrupt, PHY ports only.
//- status bit 0 shows access filter list counter interrupt.
//- toggling mask bit 0 clears status bit 0; status writes do nothing.
//- a status source reaches host interrupt only when unmasked.
//- mask register mirrors status layout; 0 enables, 1 disables.
`timescale 1ns/100ps
`include "pwei_cfg.svh"
module pwei_top
    import pwei_pkg::*;
#(
    parameter logic [2:0] PORT_NUM  = 3'd1,
    parameter bit         HAS_PHY   = 1'b1,
    parameter int         MAC_BYTES = 6
)
(
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic      [31:0]             hrdata,
    output logic                         hreadyout,
    output logic                         hresp,
    input  wire logic [47:0]             switch_mac_addr,
    input  wire pwei_wake_frame_t        wake_frame,
    input  wire logic                    link_up_det,
    input  wire logic                    energy_det,
    input  wire logic                    serdes_an_done,
    input  wire logic                    phy_irq,
    input  wire logic                    filter_counter_irq,
    output logic                         power_event_pin,
    output logic                         port_irq,
    output logic                         irq
);
    initial
    begin
        if (MAC_BYTES * 8 != `PWEI_MAC_ADDR_W)
            $error("pwei_top: MAC_BYTES must be 6");
    end

    function automatic logic [7:0] pwei_rd8(input logic [7:0] v);
        pwei_rd8 = v;
    endfunction

    function automatic logic pwei_is_reg(input logic [31:0] a, input logic [11:0] idx);
        pwei_is_reg = (a[`PWEI_ADDR_W-1:2] == idx);
    endfunction

    // pin-side detector levels cross in through two flops
    logic [3:0] pin_sync;
    logic [3:0] pin_rise;
    pwei_sync #(.WIDTH(4)) u_sync
    (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in ({energy_det, link_up_det, serdes_an_done, phy_irq}),
        .sync_out (pin_sync)
    );
    pwei_edge #(.WIDTH(4)) u_edge
    (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .level_in (pin_sync),
        .rise_out (pin_rise)
    );

    wire logic energy_rise  = pin_rise[3];
    wire logic link_rise    = pin_rise[2];
    wire logic serdes_level = pin_sync[1];
    wire logic phy_level    = pin_sync[0];

    // bus address phase
    pwei_bus_req_t req_q;
    pwei_bus_req_t req_d;
    pwei_bus_state_t st_q;
    logic [7:0] wake_flags_q;
    logic [7:0] wake_en_q;
    logic [7:0] int_mask_q;
    logic       filter_flag_q;
    logic [7:0] irq_stat_q;
    logic [7:0] irq_mask_q;
    logic [7:0] irq_stat_d;
    logic [7:0] wake_flags_d;

    wire logic addr_ph = hsel & hready & htrans[1];
    assign req_d = '{sel: addr_ph, write: hwrite, addr: haddr[`PWEI_ADDR_W-1:0]};

    wire logic [31:0] daddr = {18'h00000, req_q.addr};
    wire logic wr_ph = req_q.sel & req_q.write;
    // reads decode in the address phase so hrdata stands through the data phase
    wire logic rd_ph = addr_ph & ~hwrite;
    wire logic sel_wflags = pwei_is_reg(daddr, `PWEI_IDX_WAKE_FLAGS);
    wire logic sel_wen    = pwei_is_reg(daddr, `PWEI_IDX_WAKE_ENABLES);
    wire logic sel_iflags = pwei_is_reg(daddr, `PWEI_IDX_INT_FLAGS);
    wire logic sel_imask  = pwei_is_reg(daddr, `PWEI_IDX_INT_MASK);
    wire logic sel_istat  = pwei_is_reg(daddr, `PWEI_IDX_IRQ_STATUS);
    wire logic sel_irqm   = pwei_is_reg(daddr, `PWEI_IDX_IRQ_MASK);
    wire logic [7:0] wdat = hwdata[7:0];
    wire logic rsel_wflags = pwei_is_reg(haddr, `PWEI_IDX_WAKE_FLAGS);
    wire logic rsel_wen    = pwei_is_reg(haddr, `PWEI_IDX_WAKE_ENABLES);
    wire logic rsel_iflags = pwei_is_reg(haddr, `PWEI_IDX_INT_FLAGS);
    wire logic rsel_imask  = pwei_is_reg(haddr, `PWEI_IDX_INT_MASK);
    wire logic rsel_istat  = pwei_is_reg(haddr, `PWEI_IDX_IRQ_STATUS);
    wire logic rsel_irqm   = pwei_is_reg(haddr, `PWEI_IDX_IRQ_MASK);

    // wake event detection
    wire logic frame_match = wake_frame.valid & (wake_frame.dest_addr == switch_mac_addr);
    wire logic link_evt    = HAS_PHY & link_rise;
    wire logic energy_evt  = HAS_PHY & energy_rise;
    wire pwei_wake_evt_t wake_evt = '{energy: energy_evt, link_up: link_evt,
                                     wake_frame: frame_match};

    wire logic [7:0] wake_set = {5'h00, wake_evt.wake_frame, wake_evt.link_up, wake_evt.energy};
    wire logic [7:0] wake_clr = (wr_ph & sel_wflags) ? (wdat & `PWEI_WAKE_MASK) : 8'h00;
    assign wake_flags_d = ((wake_flags_q & ~wake_clr) | wake_set) & `PWEI_WAKE_MASK;

    // port interrupt sources
    wire logic serdes_bit = (PORT_NUM == `PWEI_SERDES_PORT) & serdes_level;
    wire logic phy_bit    = HAS_PHY & phy_level;
    wire logic [7:0] mask_wr = wdat & `PWEI_INT_MASK_BITS;
    wire logic mask_wr_ev = wr_ph & sel_imask;
    wire logic filter_toggle = mask_wr_ev &
        (mask_wr[`PWEI_BIT_FILTER] != int_mask_q[`PWEI_BIT_FILTER]);
    wire logic filter_d = filter_counter_irq | (filter_flag_q & ~filter_toggle);
    wire pwei_int_src_t src = '{serdes_an: serdes_bit, phy: phy_bit, filter: filter_flag_q};
    wire logic [7:0] int_flags = {4'h0, src.serdes_an, 1'b0, src.phy, src.filter};
    wire logic [7:0] int_enabled = int_flags & ~int_mask_q;

    // sticky event status for the interrupt line
    wire logic [7:0] irq_events = {4'h0, wake_set[2:0], |int_enabled};
    wire logic irq_rd_clr = rd_ph & rsel_istat;
    assign irq_stat_d = (irq_rd_clr ? 8'h00 : irq_stat_q) | irq_events;

    wire logic power_event_d = |(wake_flags_q & wake_en_q & `PWEI_WAKE_MASK);

    wire logic [7:0] rd_val =
        rsel_wflags ? pwei_rd8(wake_flags_q) :
        rsel_wen    ? pwei_rd8(wake_en_q) :
        rsel_iflags ? pwei_rd8(int_flags) :
        rsel_imask  ? pwei_rd8(int_mask_q) :
        rsel_istat  ? pwei_rd8(irq_stat_q) :
        rsel_irqm   ? pwei_rd8(irq_mask_q) : 8'h00;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            req_q <= '0;
        else if (hready)
            req_q <= req_d;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            st_q <= PWEI_IDLE;
        else
        begin
            case (st_q)
                PWEI_IDLE, PWEI_WRITE, PWEI_READ:
                    st_q <= !addr_ph ? PWEI_IDLE : (hwrite ? PWEI_WRITE : PWEI_READ);
                default:
                    st_q <= PWEI_IDLE;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wake_flags_q <= `PWEI_RST_WAKE_FLAGS;
            filter_flag_q <= 1'b0;
            irq_stat_q   <= 8'h00;
            hrdata       <= 32'h0000_0000;
        end
        else
        begin
            wake_flags_q <= wake_flags_d;
            filter_flag_q <= filter_d;
            irq_stat_q   <= irq_stat_d;
            if (rd_ph)
                hrdata <= {24'h000000, rd_val};
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wake_en_q  <= `PWEI_RST_WAKE_ENABLES;
            int_mask_q <= `PWEI_RST_INT_MASK;
            irq_mask_q <= `PWEI_RST_IRQ_MASK;
        end
        else if (wr_ph)
        begin
            if (sel_wen)
                wake_en_q <= wdat & `PWEI_WAKE_MASK;
            if (sel_imask)
                int_mask_q <= mask_wr;
            if (sel_irqm)
                irq_mask_q <= wdat & 8'h0f;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            power_event_pin <= 1'b0;
            port_irq        <= 1'b0;
            irq             <= 1'b0;
            hreadyout       <= 1'b1;
            hresp           <= 1'b0;
        end
        else
        begin
            power_event_pin <= power_event_d;
            port_irq        <= |int_enabled;
            irq             <= |(irq_stat_d & ~irq_mask_q);
            hreadyout       <= 1'b1;
            hresp           <= 1'b0;
        end
    end
endmodule

// ===== test/pwei_assertions.sv
`timescale 1ns/100ps
module pwei_assertions
    import pwei_pkg::*;
(
    input wire logic             hclk,
    input wire logic             hresetn,
    input wire logic             hsel,
    input wire logic [1:0]       htrans,
    input wire logic             hwrite,
    input wire logic             hready,
    input wire logic [31:0]      hrdata,
    input wire logic             hreadyout,
    input wire logic             hresp,
    input wire pwei_wake_frame_t wake_frame,
    input wire logic             link_up_det,
    input wire logic             energy_det,
    input wire logic             serdes_an_done,
    input wire logic             phy_irq,
    input wire logic             filter_counter_irq,
    input wire logic             power_event_pin,
    input wire logic             port_irq,
    input wire logic             irq
);
    logic       xfer;
    logic       rd;
    logic       wr;
    logic       cause;
    logic [3:0] quiet_q;
    assign xfer = hsel && hready && htrans[1];
    assign rd = xfer && !hwrite;
    assign wr = xfer && hwrite;
    assign cause = xfer || wake_frame.valid || link_up_det || energy_det || serdes_an_done
                   || phy_irq || filter_counter_irq;
    // cycles since anything could have moved an output
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            quiet_q <= 4'hf;
        else if (cause)
            quiet_q <= 4'h0;
        else if (quiet_q != 4'hf)
            quiet_q <= quiet_q + 4'h1;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    a_ready_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_reserved_zero: assert property (hrdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_rdata_on_read: assert property ($changed(hrdata) |-> $past(rd) || $past(rd, 2))
        else $error("read data moved without a read");
    a_reset_quiet: assert property (disable iff (1'b0)
        !hresetn && !$past(hresetn) |-> !power_event_pin && !port_irq && !irq)
        else $error("outputs active in reset");
    a_event_cause: assert property ($rose(power_event_pin) |-> quiet_q < 4'h8)
        else $error("event pin rose without cause");
    a_port_irq_cause: assert property ($rose(port_irq) |-> quiet_q < 4'h8)
        else $error("port interrupt rose without cause");
    a_irq_cause: assert property ($rose(irq) |-> quiet_q < 4'h8)
        else $error("interrupt rose without cause");
    a_event_clear_write: assert property ($fell(power_event_pin)
        |-> $past(wr, 2) || $past(wr, 3))
        else $error("event pin fell without a write");
    a_port_irq_drop: assert property ($fell(port_irq) |-> quiet_q < 4'h8)
        else $error("port interrupt fell without cause");
endmodule
bind pwei_top pwei_assertions pwei_assertions_i (.hclk, .hresetn, .hsel, .htrans, .hwrite,
    .hready, .hrdata, .hreadyout, .hresp, .wake_frame, .link_up_det, .energy_det,
    .serdes_an_done, .phy_irq, .filter_counter_irq, .power_event_pin, .port_irq, .irq);

// ===== test/pwei_evt_src.sv
`timescale 1ns/100ps
module pwei_evt_src
    import pwei_pkg::*;
(
    input  wire logic        hclk,
    output logic [47:0]      switch_mac_addr,
    output pwei_wake_frame_t wake_frame,
    output logic             link_up_det,
    output logic             energy_det,
    output logic             serdes_an_done,
    output logic             phy_irq,
    output logic             filter_counter_irq
);
    // arbitrary value
    localparam logic [47:0] OWN_MAC = 48'h02a5_5a13_37c0;
    initial
    begin
        switch_mac_addr = OWN_MAC;
        wake_frame = '0;
        {link_up_det, energy_det, serdes_an_done, phy_irq, filter_counter_irq} = 5'h00;
    end
    task frame(input logic [47:0] dest);
        @(posedge hclk);
        wake_frame <= {1'b1, dest};
        @(posedge hclk);
        wake_frame <= {1'b0, ~dest};
    endtask
    task filter_hit;
        @(posedge hclk);
        filter_counter_irq <= 1'b1;
        @(posedge hclk);
        filter_counter_irq <= 1'b0;
    endtask
    task lvl(input logic [3:0] v);
        @(posedge hclk);
        {link_up_det, energy_det, serdes_an_done, phy_irq} <= v;
    endtask
endmodule

// ===== test/testbench.sv
`timescale 1ns/100ps
`include "pwei_cfg.svh"
module testbench
    import pwei_pkg::*;
;
    localparam logic [31:0] WF = 4 * `PWEI_IDX_WAKE_FLAGS;
    localparam logic [31:0] WE = 4 * `PWEI_IDX_WAKE_ENABLES;
    localparam logic [31:0] IF = 4 * `PWEI_IDX_INT_FLAGS;
    localparam logic [31:0] IM = 4 * `PWEI_IDX_INT_MASK;
    localparam logic [31:0] IS = 4 * `PWEI_IDX_IRQ_STATUS;
    localparam logic [31:0] IQ = 4 * `PWEI_IDX_IRQ_MASK;
    logic             hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic             power_event_pin, port_irq, irq, link_up_det, energy_det;
    logic             serdes_an_done, phy_irq, filter_counter_irq;
    logic [1:0]       htrans;
    logic [2:0]       hsize;
    logic [31:0]      haddr, hwdata, hrdata, rd;
    logic [47:0]      mac;
    pwei_wake_frame_t wake_frame;
    int               fails, comparisons;
    pwei_top pwei_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .switch_mac_addr(mac), .wake_frame,
        .link_up_det, .energy_det, .serdes_an_done, .phy_irq, .filter_counter_irq,
        .power_event_pin, .port_irq, .irq);
    pwei_evt_src pwei_evt_src_i (.hclk, .switch_mac_addr(mac), .wake_frame, .link_up_det,
        .energy_det, .serdes_an_done, .phy_irq, .filter_counter_irq);
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        {hsel, hwrite, htrans, haddr} <= {1'b1, w, 2'b10, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        {hsel, htrans} <= 3'b000;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task rdc(input logic [31:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task pins(input int n, input logic [2:0] exp);
        repeat (n) @(posedge hclk);
        @(negedge hclk);
        chk({29'h0, power_event_pin, port_irq, irq}, {29'h0, exp});
    endtask
    task print_verdict;
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'b010;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(WF, 32'h0);
        rdc(IF, 32'h0);
        rdc(IM, 32'h0);
        ahb(1'b1, 32'h200, 32'hff);
        rdc(32'h200, 32'h0);
        ahb(1'b1, WE, 32'hff);
        rdc(WE, 32'h07);
        pwei_evt_src_i.frame(~mac);
        pins(4, 3'b000);
        pwei_evt_src_i.frame(mac);
        pins(4, 3'b101);
        rdc(WF, 32'h04);
        ahb(1'b1, WF, 32'h04);
        rdc(IS, 32'h08);
        pins(3, 3'b000);
        $display("test wake frame done");
        ahb(1'b1, WE, 32'h00);
        pwei_evt_src_i.lvl(4'b1100);
        pins(8, 3'b001);
        rdc(WF, 32'h03);
        ahb(1'b1, WE, 32'h03);
        pins(3, 3'b101);
        rdc(IS, 32'h06);
        ahb(1'b1, WF, 32'h03);
        pwei_evt_src_i.lvl(4'b0000);
        pins(3, 3'b000);
        $display("test link and energy done");
        pwei_evt_src_i.filter_hit();
        pins(3, 3'b011);
        ahb(1'b1, IF, 32'h00);
        rdc(IF, 32'h01);
        ahb(1'b1, IM, 32'h01);
        rdc(IF, 32'h00);
        rdc(IM, 32'h01);
        pwei_evt_src_i.filter_hit();
        pins(3, 3'b001);
        rdc(IF, 32'h01);
        ahb(1'b1, IM, 32'h00);
        rdc(IF, 32'h00);
        rdc(IS, 32'h01);
        pins(2, 3'b000);
        $display("test filter list done");
        ahb(1'b1, IQ, 32'h0f);
        rdc(IQ, 32'h0f);
        pwei_evt_src_i.lvl(4'b0011);
        pins(8, 3'b010);
        rdc(IF, 32'h02);
        pwei_evt_src_i.lvl(4'b0000);
        pins(8, 3'b000);
        rdc(IS, 32'h01);
        $display("test phy and masks done");
        print_verdict();
    end
    initial
    begin
        repeat (3000) @(posedge hclk);
        fails++;
        print_verdict();
    end
endmodule
